// ==== verilog/dr_defs.svh ====
// Register map, field positions and codes of the rate select block.
// Included by the package and the design; definitions only.
`ifndef DR_DEFS_SVH
`define DR_DEFS_SVH

// Register offsets on the plain register port
`define DR_ADDR_W 3
`define DR_OFS_CSEL_A 3'h0
`define DR_OFS_CMD_A 3'h1
`define DR_OFS_CSEL_B 3'h2
`define DR_OFS_CMD_B 3'h3
`define DR_OFS_MODE0 3'h4
`define DR_OFS_AUX 3'h5
`define DR_OFS_STATUS 3'h6

// Reset values
`define DR_RST_BYTE 8'h00
`define DR_RST_DIV 13'h0000

// Clock select nibble codes
`define DR_CODE_TIMER 4'hD
`define DR_CODE_EXT16 4'hE
`define DR_CODE_EXT1 4'hF

// Command register fields
`define DR_CMD_RX_LSB 0
`define DR_CMD_TX_LSB 2
`define DR_CMD_NOP 2'h0
`define DR_CMD_EN 2'h1
`define DR_CMD_DIS 2'h2

// Table and set select bits
`define DR_MODE0_EXT1_BIT 0
`define DR_MODE0_EXT2_BIT 2
`define DR_AUX_SET_BIT 7

// Reference of 3.6864 MHz made from a 200 MHz clock: 2^32 * f_ref / f_clk
`define DR_REF_INC 32'h04B7F5A5

`endif

// ==== verilog/dr_pkg.sv ====
// Types shared by the rate select block.
// Assumes dr_defs.svh is on the include path.
`include "dr_defs.svh"

package dr_pkg;
  typedef enum logic [1:0] {DR_TBL_STD, DR_TBL_EXT1, DR_TBL_EXT2} dr_tbl_t;
  typedef logic [12:0] dr_div_t;
  typedef logic [`DR_ADDR_W-1:0] dr_addr_t;
endpackage

// ==== verilog/dr_rate_sel.sv ====
// Per-channel rate select and receiver/transmitter enable decode.
// Assumes a same-clock register port and external clocks from pins.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "dr_defs.svh"

// Functional notes
// - Clock select low nibble picks transmitter rate source per channel.
// - Clock select high nibble picks receiver rate source, independently.
// - Mode zero bits 0/2 pick table; aux bit 7 picks set.
// - Codes 0000-1100 give tabulated rates; 1101 takes timer 16X tick.
// - Table rates divide the reference, so double reference doubles rates.
// - Code 1110 uses the direction's external pin as 16X clock.
// - Code 1111 uses the same pin as a 1X bit clock.
// - External clock rates ignore table and set select bits.
// - Each channel has its own command register acting only on it.
// - All fields of one command write act together.
// - Receiver field: 00 hold, 01 enable, 10 disable, 11 unused.
// - Transmitter field: 00 hold, 01 enable, 10 disable, 11 unused.
// - Transmitter empty clears on disable and on character load.
module dr_rate_sel #(
  parameter logic [31:0] REF_INC = `DR_REF_INC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dr_pkg::dr_addr_t reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ct_16x_tick,
  input wire logic chan_a_tx_ext_clock_in,
  input wire logic chan_a_rx_ext_clock_in,
  input wire logic chan_b_tx_ext_clock_in,
  input wire logic chan_b_rx_ext_clock_in,
  input wire logic tx_load_a,
  input wire logic tx_load_b,
  input wire logic tx_done_a,
  input wire logic tx_done_b,
  output logic tx_en_a,
  output logic rx_en_a,
  output logic tx_en_b,
  output logic rx_en_b,
  output logic tx_empty_a,
  output logic tx_empty_b,
  output logic tx_tick_a,
  output logic rx_tick_a,
  output logic tx_tick_b,
  output logic rx_tick_b,
  output logic tx_x1_a,
  output logic rx_x1_a,
  output logic tx_x1_b,
  output logic rx_x1_b
);
  import dr_pkg::*;

  // Divisor of the 3.6864 MHz reference for one 16X tick
  function automatic dr_div_t pick6(input dr_tbl_t t, input logic s,
      input dr_div_t a, input dr_div_t b, input dr_div_t c,
      input dr_div_t d, input dr_div_t e, input dr_div_t f);
    dr_div_t r;
    r = s ? b : a;
    case (t)
      DR_TBL_EXT1: r = s ? d : c;
      DR_TBL_EXT2: r = s ? f : e;
      default: r = s ? b : a;
    endcase
    return r;
  endfunction

  function automatic dr_div_t rate_div(input dr_tbl_t t, input logic s,
      input logic [3:0] code);
    dr_div_t r;
    r = 13'h0001;
    case (code)
      4'h0: r = pick6(t, s, 13'h1200, 13'h0C00, 13'h0300, 13'h0200,
                      13'h0030, 13'h0020);
      4'h1: r = pick6(t, s, 13'h082F, 13'h082F, 13'h082F, 13'h082F,
                      13'h0106, 13'h0106);
      4'h2: r = pick6(t, s, 13'h06B1, 13'h06B1, 13'h06B1, 13'h06B1,
                      13'h00D6, 13'h00D6);
      4'h3: r = pick6(t, s, 13'h0480, 13'h0600, 13'h00C0, 13'h0100,
                      13'h000C, 13'h0010);
      4'h4: r = pick6(t, s, 13'h0300, 13'h0300, 13'h0080, 13'h0080,
                      13'h0008, 13'h0008);
      4'h5: r = pick6(t, s, 13'h0180, 13'h0180, 13'h0040, 13'h0040,
                      13'h0004, 13'h0004);
      4'h6: r = pick6(t, s, 13'h00C0, 13'h00C0, 13'h0020, 13'h0020,
                      13'h0002, 13'h0002);
      4'h7: r = pick6(t, s, 13'h00DB, 13'h0073, 13'h00DB, 13'h0073,
                      13'h00DB, 13'h0073);
      4'h8: r = pick6(t, s, 13'h0060, 13'h0060, 13'h0010, 13'h0010,
                      13'h0004, 13'h0004);
      4'h9: r = pick6(t, s, 13'h0030, 13'h0030, 13'h0008, 13'h0008,
                      13'h0030, 13'h0030);
      4'hA: r = pick6(t, s, 13'h0020, 13'h0080, 13'h0020, 13'h0080,
                      13'h0004, 13'h0010);
      4'hB: r = pick6(t, s, 13'h0018, 13'h0018, 13'h0004, 13'h0004,
                      13'h0018, 13'h0018);
      4'hC: r = pick6(t, s, 13'h0006, 13'h000C, 13'h0001, 13'h0002,
                      13'h0006, 13'h000C);
      default: r = 13'h0001;
    endcase
    return r;
  endfunction

  // Enable state after a two-bit command field
  function automatic logic cmd_apply(input logic cur, input logic [1:0] f);
    logic r;
    r = cur;
    case (f)
      `DR_CMD_EN: r = 1'b1;
      `DR_CMD_DIS: r = 1'b0;
      default: r = cur;
    endcase
    return r;
  endfunction

  logic rst_s1_r;
  logic rst_s2_r;
  wire rst_n = rst_s2_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Register file
  logic [7:0] csel_r [2];
  logic [7:0] mode0_r;
  logic [7:0] aux_r;
  logic [7:0] rdata_r;

  wire wr_csel_a = reg_wr && reg_addr == `DR_OFS_CSEL_A;
  wire wr_csel_b = reg_wr && reg_addr == `DR_OFS_CSEL_B;
  wire wr_cmd_a = reg_wr && reg_addr == `DR_OFS_CMD_A;
  wire wr_cmd_b = reg_wr && reg_addr == `DR_OFS_CMD_B;
  wire wr_mode0 = reg_wr && reg_addr == `DR_OFS_MODE0;
  wire wr_aux = reg_wr && reg_addr == `DR_OFS_AUX;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csel_r[0] <= `DR_RST_BYTE;
      csel_r[1] <= `DR_RST_BYTE;
      mode0_r <= `DR_RST_BYTE;
      aux_r <= `DR_RST_BYTE;
    end else begin
      if (wr_csel_a) csel_r[0] <= reg_wdata;
      if (wr_csel_b) csel_r[1] <= reg_wdata;
      if (wr_mode0) mode0_r <= reg_wdata;
      if (wr_aux) aux_r <= reg_wdata;
    end
  end

  wire m_ext1 = mode0_r[`DR_MODE0_EXT1_BIT];
  wire m_ext2 = mode0_r[`DR_MODE0_EXT2_BIT];
  wire dr_tbl_t tbl = (m_ext1 && !m_ext2) ? DR_TBL_EXT1 :
                      (m_ext2 && !m_ext1) ? DR_TBL_EXT2 : DR_TBL_STD;
  wire set2 = aux_r[`DR_AUX_SET_BIT];

  // Reference tick from a phase accumulator
  logic [31:0] acc_r;
  logic ref_tick_r;
  wire [32:0] acc_sum = {1'b0, acc_r} + {1'b0, REF_INC};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 32'h00000000;
      ref_tick_r <= 1'b0;
    end else begin
      acc_r <= acc_sum[31:0];
      ref_tick_r <= acc_sum[32];
    end
  end

  // External clock pins, two-stage synchronised, then edge found
  wire [3:0] ext_pin = {chan_b_rx_ext_clock_in, chan_b_tx_ext_clock_in,
                        chan_a_rx_ext_clock_in, chan_a_tx_ext_clock_in};
  logic [3:0] ext_s1_r;
  logic [3:0] ext_s2_r;
  logic [3:0] ext_s3_r;
  wire [3:0] ext_rise = ext_s2_r & ~ext_s3_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      ext_s3_r <= 4'h0;
    end else begin
      ext_s1_r <= ext_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Direction index: 0 tx A, 1 rx A, 2 tx B, 3 rx B
  logic [3:0] en_r;
  logic [3:0] tick_r;
  logic [3:0] x1_r;
  wire [3:0] cmd_wr = {wr_cmd_b, wr_cmd_b, wr_cmd_a, wr_cmd_a};

  for (genvar d = 0; d < 4; d++) begin : g_dir
    wire [7:0] csel = csel_r[d / 2];
    wire [3:0] code = (d % 2 == 1) ? csel[7:4] : csel[3:0];
    wire [7:0] cmd = reg_wdata;
    wire [1:0] field = (d % 2 == 1) ?
        cmd[`DR_CMD_RX_LSB +: 2] : cmd[`DR_CMD_TX_LSB +: 2];
    wire is_ext = code == `DR_CODE_EXT16 || code == `DR_CODE_EXT1;
    wire is_timer = code == `DR_CODE_TIMER;
    wire dr_div_t div = rate_div(tbl, set2, code);
    dr_div_t cnt_r;
    wire reload = cnt_r == `DR_RST_DIV || cnt_r >= div;
    wire div_tick = ref_tick_r && cnt_r == `DR_RST_DIV;
    wire src_tick = is_ext ? ext_rise[d] :
                    is_timer ? ct_16x_tick : div_tick;

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r <= `DR_RST_DIV;
        en_r[d] <= 1'b0;
        tick_r[d] <= 1'b0;
        x1_r[d] <= 1'b0;
      end else begin
        if (ref_tick_r) cnt_r <= reload ? div - 13'h0001 : cnt_r - 13'h0001;
        if (cmd_wr[d]) en_r[d] <= cmd_apply(en_r[d], field);
        tick_r[d] <= en_r[d] && src_tick;
        x1_r[d] <= code == `DR_CODE_EXT1;
      end
    end
  end

  // Transmitter empty; set by completion wins over clears
  logic [1:0] empty_r;
  wire [1:0] tx_dis = {wr_cmd_b, wr_cmd_a} &
      {2{reg_wdata[`DR_CMD_TX_LSB +: 2] == `DR_CMD_DIS}};
  wire [1:0] tx_load = {tx_load_b, tx_load_a};
  wire [1:0] tx_done = {tx_done_b, tx_done_a};
  wire [1:0] empty_nxt = tx_done | (empty_r & ~tx_load & ~tx_dis);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) empty_r <= 2'h0;
    else empty_r <= empty_nxt;
  end

  // Read side; write-only registers read as zero
  wire [7:0] status = {2'h0, empty_r[1], en_r[2], en_r[3],
                       empty_r[0], en_r[0], en_r[1]};
  wire [7:0] rd_mux = reg_addr == `DR_OFS_MODE0 ? mode0_r :
                      reg_addr == `DR_OFS_AUX ? aux_r :
                      reg_addr == `DR_OFS_STATUS ? status : `DR_RST_BYTE;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdata_r <= `DR_RST_BYTE;
    else rdata_r <= reg_rd ? rd_mux : `DR_RST_BYTE;
  end

  assign reg_rdata = rdata_r;
  assign tx_en_a = en_r[0];
  assign rx_en_a = en_r[1];
  assign tx_en_b = en_r[2];
  assign rx_en_b = en_r[3];
  assign tx_empty_a = empty_r[0];
  assign tx_empty_b = empty_r[1];
  assign tx_tick_a = tick_r[0];
  assign rx_tick_a = tick_r[1];
  assign tx_tick_b = tick_r[2];
  assign rx_tick_b = tick_r[3];
  assign tx_x1_a = x1_r[0];
  assign rx_x1_a = x1_r[1];
  assign tx_x1_b = x1_r[2];
  assign rx_x1_b = x1_r[3];

endmodule

// ==== bench/dr_rate_sel_asserts.sv ====
// Port checker of the rate select block.
// Bound to dr_rate_sel below; sees only its ports.
`timescale 1ns/1ps
module dr_rate_sel_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dr_pkg::dr_addr_t reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ct_16x_tick,
  input wire logic tx_load_a,
  input wire logic tx_done_a,
  input wire logic tx_en_a,
  input wire logic rx_en_a,
  input wire logic tx_en_b,
  input wire logic rx_en_b,
  input wire logic tx_empty_a,
  input wire logic tx_empty_b,
  input wire logic tx_tick_a,
  input wire logic rx_x1_b
);
  import dr_pkg::*;
  logic [7:0] csa_r;
  logic [7:0] csb_r;
  wire cmd_a = reg_wr && reg_addr == 3'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Shadow of the write-only clock selects
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      csa_r <= 8'h00;
      csb_r <= 8'h00;
    end else if (reg_wr && reg_addr == 3'h0) begin
      csa_r <= reg_wdata;
    end else if (reg_wr && reg_addr == 3'h2) begin
      csb_r <= reg_wdata;
    end
  end
  status_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h6
    |-> reg_rdata == {2'b00, $past(tx_empty_b), $past(tx_en_b), $past(rx_en_b),
    $past(tx_empty_a), $past(tx_en_a), $past(rx_en_a)}) else $error("status");
  wo_read_a: assert property ($past(reg_rd) && $past(reg_addr) < 3'h4
    |-> reg_rdata == 8'h00) else $error("write-only read not zero");
  rx_cmd_a: assert property (cmd_a && reg_wdata[1:0] inside {2'h1, 2'h2}
    |=> rx_en_a == $past(reg_wdata[0])) else $error("rx command");
  tx_cmd_b: assert property (reg_wr && reg_addr == 3'h3 &&
    reg_wdata[3:2] inside {2'h1, 2'h2} |=> tx_en_b == $past(reg_wdata[2]))
    else $error("tx command");
  cmd_isolate_a: assert property (reg_wr && (reg_addr != 3'h1 ||
    reg_wdata[1:0] inside {2'h0, 2'h3}) |=> $stable(rx_en_a))
    else $error("rx enable moved");
  empty_clear_a: assert property ((tx_load_a || cmd_a &&
    reg_wdata[3:2] == 2'h2) && !tx_done_a |=> !tx_empty_a)
    else $error("empty not cleared");
  timer_tick_a: assert property (csa_r[3:0] == 4'hD && tx_en_a &&
    ct_16x_tick && !reg_wr |=> tx_tick_a) else $error("timer tick lost");
  tick_gate_a: assert property (!tx_en_a && !$past(tx_en_a)
    |-> !tx_tick_a) else $error("tick while disabled");
  x1_level_b: assert property (reg_wr && reg_addr == 3'h2
    |=> ##1 rx_x1_b == (csb_r[7:4] == 4'hF)) else $error("x1 level");
  cover property (ct_16x_tick && tx_en_a);
  cover property (tx_done_a ##1 tx_empty_a);
  cover property (rx_x1_b && rx_en_b);
endmodule

bind dr_rate_sel dr_rate_sel_chk i_chk (.clk_sys, .nrst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ct_16x_tick, .tx_load_a,
  .tx_done_a, .tx_en_a, .rx_en_a, .tx_en_b, .rx_en_b, .tx_empty_a,
  .tx_empty_b, .tx_tick_a, .rx_x1_b);

// ==== bench/dr_ext_clk_src.sv ====
// Far-side clock source for the external clock pins.
// Rests low between frames; 160 ns period within a frame.
`timescale 1ns/1ps
module dr_ext_clk_src (
  input wire logic go,
  input wire logic [7:0] n_edges,
  output logic clk_out
);
  initial clk_out = 1'b0;
  always @(posedge go) begin
    repeat (n_edges) begin
      #80 clk_out = 1'b1;
      #80 clk_out = 1'b0;
    end
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench of the rate select block.
// Register port driven here; pins from dr_ext_clk_src.
`timescale 1ns/1ps
module testbench;
  import dr_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  dr_addr_t reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] pls = 3'h0;
  logic go = 1'b0;
  logic [7:0] n_edges = 8'h0C;
  logic [7:0] reg_rdata, rdata;
  logic ext_clk, tx_en_a, rx_en_a, tx_en_b, rx_en_b, tx_empty_a, tx_empty_b;
  logic tx_tick_a, rx_tick_a, tx_tick_b, rx_tick_b;
  logic tx_x1_a, rx_x1_a, tx_x1_b, rx_x1_b;
  int miscompares = 0;
  int checks = 0;
  int n_txa = 0, n_rxa = 0, n_txb = 0, n_rxb = 0, s0, s1;
  logic [7:0] t_mode [5] = '{8'h00, 8'h00, 8'h01, 8'h04, 8'h04};
  logic [7:0] t_aux [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h80};
  logic [7:0] t_csel [5] = '{8'hDC, 8'hDC, 8'hDC, 8'hD6, 8'hD3};
  int t_exp [5] = '{40, 20, 240, 120, 15};
  dr_rate_sel i_dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ct_16x_tick(pls[2]), .chan_a_tx_ext_clock_in(ext_clk),
    .chan_a_rx_ext_clock_in(ext_clk), .chan_b_tx_ext_clock_in(ext_clk),
    .chan_b_rx_ext_clock_in(ext_clk), .tx_load_a(pls[1]), .tx_load_b(1'b0),
    .tx_done_a(pls[0]), .tx_done_b(pls[0]), .tx_en_a, .rx_en_a, .tx_en_b,
    .rx_en_b, .tx_empty_a, .tx_empty_b, .tx_tick_a, .rx_tick_a, .tx_tick_b,
    .rx_tick_b, .tx_x1_a, .rx_x1_a, .tx_x1_b, .rx_x1_b);
  dr_ext_clk_src i_src (.go, .n_edges, .clk_out(ext_clk));
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_txa <= n_txa + int'(tx_tick_a);
    n_rxa <= n_rxa + int'(rx_tick_a);
    n_txb <= n_txb + int'(tx_tick_b);
    n_rxb <= n_rxb + int'(rx_tick_b);
  end
  task automatic wr(input dr_addr_t a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp, input int tol);
    checks++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic rdchk(input dr_addr_t a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rdata = reg_rdata;
    chk8(rdata, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys);
    pls[i] <= 1'b1;
    @(posedge clk_sys);
    pls <= 3'h0;
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk8({tx_en_a, rx_en_a, tx_empty_a, tx_tick_a, tx_x1_b, 3'h0}, 8'h00);
    rdchk(3'h6, 8'h00);
    wr(3'h4, 8'h05);
    rdchk(3'h4, 8'h05);
    wr(3'h0, 8'h5A);
    rdchk(3'h0, 8'h00);
    rdchk(3'h7, 8'h00);
    wr(3'h1, 8'hF5);
    rdchk(3'h6, 8'h03);
    wr(3'h3, 8'h05);
    rdchk(3'h6, 8'h1B);
    wr(3'h1, 8'h0F);
    rdchk(3'h6, 8'h1B);
    wr(3'h1, 8'h06);
    rdchk(3'h6, 8'h1A);
    wr(3'h1, 8'h09);
    rdchk(3'h6, 8'h19);
    wr(3'h1, 8'h05);
    pulse(0);
    rdchk(3'h6, 8'h3F);
    pulse(1);
    rdchk(3'h6, 8'h3B);
    pulse(0);
    wr(3'h1, 8'h08);
    rdchk(3'h6, 8'h39);
    wr(3'h1, 8'h05);
    wr(3'h0, 8'hDD);
    pulse(2);
    @(posedge clk_sys);
    chk8({6'h00, tx_tick_a, rx_tick_a}, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(3'h4, t_mode[i]);
      wr(3'h5, t_aux[i]);
      wr(3'h0, t_csel[i]);
      s0 = n_txa;
      s1 = n_rxa;
      repeat (13020) @(posedge clk_sys);
      chk_cnt(n_txa - s0, t_exp[i], 1);
      chk_cnt(n_rxa - s1, 0, 0);
    end
    wr(3'h2, 8'hFE);
    for (int i = 0; i < 2; i++) begin
      wr(3'h4, i ? 8'h05 : 8'h00);
      wr(3'h5, i ? 8'h80 : 8'h00);
      s0 = n_txb;
      s1 = n_rxb;
      go <= 1'b1;
      repeat (420) @(posedge clk_sys);
      go <= 1'b0;
      chk_cnt(n_txb - s0, 12, 0);
      chk_cnt(n_rxb - s1, 12, 0);
    end
    chk8({4'h0, tx_x1_a, rx_x1_a, tx_x1_b, rx_x1_b}, 8'h01);
    print_verdict();
  end
endmodule
